// *** nesr_defines.vh ***
// Constants for the node error status and link reset block.
// Assumes inclusion by bare name from each design file of the block that uses its constants.
`ifndef NESR_DEFINES_VH
`define NESR_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (byte addresses on the processor memory bus)
// ----------------------------------------------------------------------
`define NESR_ID_BASE        32'h0000_0000
`define NESR_ID_COUNT       3'h7
`define NESR_STATUS_ADDR    32'h0000_0080
`define NESR_RSTCTL_ADDR    32'h0000_00c0
`define NESR_MEM_TOP        32'h801f_ffff

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define NESR_ST_PROC_BIT    0
`define NESR_ST_ADDR_BIT    1
`define NESR_JMP_FAULT_BIT  0
`define NESR_JMP_EVENT_BIT  1
`define NESR_JMP_ANAL_BIT   2
`define NESR_UNLOCK_V0      8'h00
`define NESR_UNLOCK_V1      8'h01
`define NESR_UNLOCK_V2      8'h02
`define NESR_UNLOCK_V3      8'h03
`define NESR_RELEASE_V      8'h00

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define NESR_ERR_RST        1'b0
`define NESR_MASK_RST       4'h0
`define NESR_CLK_MHZ        20
`define NESR_LINK_MBPS      8'h0a
`define NESR_MEM_ACCESS_NS  100
`define NESR_MEM_CYCLES     ((`NESR_MEM_ACCESS_NS * `NESR_CLK_MHZ + 999) / 1000)

`endif

// *** nesr_sync.v ***
// Two-flop synchroniser for a group of pin-level inputs.
// Assumes the inputs are levels that stay stable for several clock cycles.
`timescale 1ns/100ps

module nesr_sync #(
  parameter W = 1
) (
  input  wire         sys_clk_i,
  input  wire         rst_b_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);

  reg [W-1:0] meta_reg;

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= {W{1'b0}};
      sync_o   <= {W{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // nesr_sync

// *** nesr_unlock.v ***
// Unlock sequencer and link mask holder of the reset port.
// Assumes one write strobe per bus write, on the system clock.
`timescale 1ns/100ps
`include "nesr_defines.vh"

module nesr_unlock (
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  input  wire       wr_i,
  input  wire [7:0] data_i,
  output reg  [3:0] mask_o,
  output wire       open_o
);

  localparam [2:0] ST_LOCKED = 3'h0;
  localparam [2:0] ST_GOT0   = 3'h1;
  localparam [2:0] ST_GOT1   = 3'h2;
  localparam [2:0] ST_GOT2   = 3'h3;
  localparam [2:0] ST_OPEN   = 3'h4;
  localparam [2:0] ST_SEL    = 3'h5;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] mask_next;

  function is_onehot4;
    input [7:0] v;
    begin
      is_onehot4 = (v == 8'h01) || (v == 8'h02) || (v == 8'h04) || (v == 8'h08);
    end
  endfunction

  assign open_o = (state_reg == ST_OPEN);

  // Before ST_OPEN a wrong value restarts the sequence and a zero may itself begin a new one; ST_SEL ignores all but a zero.
  always @* begin
    state_next = state_reg;
    mask_next  = mask_o;
    if (wr_i) begin
      case (state_reg)
        ST_LOCKED: begin
          state_next = (data_i == `NESR_UNLOCK_V0) ? ST_GOT0 : ST_LOCKED;
        end
        ST_GOT0: begin
          if (data_i == `NESR_UNLOCK_V1) begin
            state_next = ST_GOT1;
          end else begin
            state_next = (data_i == `NESR_UNLOCK_V0) ? ST_GOT0 : ST_LOCKED;
          end
        end
        ST_GOT1: begin
          if (data_i == `NESR_UNLOCK_V2) begin
            state_next = ST_GOT2;
          end else begin
            state_next = (data_i == `NESR_UNLOCK_V0) ? ST_GOT0 : ST_LOCKED;
          end
        end
        ST_GOT2: begin
          if (data_i == `NESR_UNLOCK_V3) begin
            state_next = ST_OPEN;
          end else begin
            state_next = (data_i == `NESR_UNLOCK_V0) ? ST_GOT0 : ST_LOCKED;
          end
        end
        ST_OPEN: begin
          if (is_onehot4(data_i)) begin
            mask_next  = data_i[3:0];
            state_next = ST_SEL;
          end else begin
            state_next = ST_LOCKED;
          end
        end
        ST_SEL: begin
          if (data_i == `NESR_RELEASE_V) begin
            mask_next  = `NESR_MASK_RST;
            state_next = ST_LOCKED;
          end
        end
        default: begin
          state_next = ST_LOCKED;
          mask_next  = `NESR_MASK_RST;
        end
      endcase
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_LOCKED;
      mask_o    <= `NESR_MASK_RST;
    end else begin
      state_reg <= state_next;
      mask_o    <= mask_next;
    end
  end

endmodule // nesr_unlock

// *** nesr_top.v ***
// Node glue logic: error status, board identification, link reset port,
// error routing by jumpers and boot link selection.
// Assumes a single-cycle read or write strobe from the processor memory bus
// on sys_clk_i; all pins and jumpers arrive asynchronously.
// A jumper bit reads 1 when its A position is fitted, 0 for the B position.
// Link reset lines and link activity are active-high levels from buffers.
`timescale 1ns/100ps
`include "nesr_defines.vh"

module nesr_top #(
  // Board identification, seven bytes, byte 1 in bits 7:0. Value arbitrary.
  parameter [55:0] BOARD_ID = 56'h07_06_05_04_03_02_01
) (
  input  wire        sys_clk_i,
  input  wire        rst_b_i,
  input  wire [31:0] mem_addr_i,
  input  wire [31:0] mem_wdata_i,
  input  wire        mem_rd_i,
  input  wire        mem_wr_i,
  input  wire        proc_error_i,
  input  wire [3:0]  link_reset_in_i,
  input  wire [3:0]  link_rx_active_i,
  input  wire [2:0]  fault_routing_jumpers_i,
  output reg  [31:0] mem_rdata_o,
  output reg         mem_ack_o,
  output wire [3:0]  link_reset_out_o,
  output reg         node_reset_o,
  output reg         analyse_o,
  output reg         event_req_o,
  output reg         external_fault_input_o,
  output reg         serial_boot_setting_o,
  output reg  [1:0]  boot_link_o,
  output reg         boot_link_valid_o,
  output reg  [7:0]  link_rate_mbps_o,
  output reg  [3:0]  mem_access_cycles_o
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  wire [3:0] lrst_s;
  wire [3:0] rxact_s;
  wire [2:0] jmp_s;
  wire       perr_s;

  // Each pin group has a synchroniser of its own, so that one group can be
  // given a filter later without moving the timing of the others.
  nesr_sync #(.W(4)) u_sync_lrst (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (link_reset_in_i),
    .sync_o    (lrst_s)
  );

  nesr_sync #(.W(4)) u_sync_rxact (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (link_rx_active_i),
    .sync_o    (rxact_s)
  );

  nesr_sync #(.W(3)) u_sync_jmp (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (fault_routing_jumpers_i),
    .sync_o    (jmp_s)
  );

  nesr_sync #(.W(1)) u_sync_perr (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (proc_error_i),
    .sync_o    (perr_s)
  );

  wire lrst_any   = |lrst_s;
  wire jmp_fault  = jmp_s[`NESR_JMP_FAULT_BIT];
  wire jmp_event  = jmp_s[`NESR_JMP_EVENT_BIT];
  wire jmp_anal   = jmp_s[`NESR_JMP_ANAL_BIT];

  // --------------------------------------------------------------------
  // Local constants
  // --------------------------------------------------------------------
  // Full-width copies let decode and configuration take exactly the bits
  // they need instead of silently narrowing a wider constant.
  localparam [31:0] ID_BASE_W = `NESR_ID_BASE;
  localparam [31:0] MEM_CYC_W = `NESR_MEM_CYCLES;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function id_hit;
    input [31:0] a;
    begin
      id_hit = (a[31:5] == ID_BASE_W[31:5]) && (a[4:2] < `NESR_ID_COUNT) &&
               (a[1:0] == 2'h0);
    end
  endfunction

  function [7:0] id_byte;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    id_byte = BOARD_ID[7:0];
        3'h1:    id_byte = BOARD_ID[15:8];
        3'h2:    id_byte = BOARD_ID[23:16];
        3'h3:    id_byte = BOARD_ID[31:24];
        3'h4:    id_byte = BOARD_ID[39:32];
        3'h5:    id_byte = BOARD_ID[47:40];
        3'h6:    id_byte = BOARD_ID[55:48];
        default: id_byte = 8'h00;
      endcase
    end
  endfunction

  // The working memory sits at the bottom of the signed upper half; any
  // access in that half above its top is out of range.
  wire mem_access = mem_rd_i | mem_wr_i;
  wire addr_bad   = mem_access && mem_addr_i[31] && (mem_addr_i > `NESR_MEM_TOP);
  wire hit_id     = id_hit(mem_addr_i);
  wire hit_status = (mem_addr_i == `NESR_STATUS_ADDR);
  wire hit_rstctl = (mem_addr_i == `NESR_RSTCTL_ADDR);

  // --------------------------------------------------------------------
  // Error status
  // --------------------------------------------------------------------
  reg proc_err_reg;
  reg proc_err_next;
  reg addr_err_reg;
  reg addr_err_next;

  // A node reset from a link clears the latched errors, but an error seen
  // in that same cycle still sets its bit.
  always @* begin
    proc_err_next = lrst_any ? `NESR_ERR_RST : proc_err_reg;
    addr_err_next = lrst_any ? `NESR_ERR_RST : addr_err_reg;
    if (perr_s) begin
      proc_err_next = 1'b1;
    end
    if (addr_bad) begin
      addr_err_next = 1'b1;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      proc_err_reg <= `NESR_ERR_RST;
      addr_err_reg <= `NESR_ERR_RST;
    end else begin
      proc_err_reg <= proc_err_next;
      addr_err_reg <= addr_err_next;
    end
  end

  // --------------------------------------------------------------------
  // Reset port
  // --------------------------------------------------------------------
  nesr_unlock u_unlock (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .wr_i      (mem_wr_i & hit_rstctl),
    .data_i    (mem_wdata_i[7:0]),
    .mask_o    (link_reset_out_o),
    .open_o    ()
  );

  // --------------------------------------------------------------------
  // Bus read path
  // --------------------------------------------------------------------
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit_id) begin
      rdata_next = {24'h00_0000, id_byte(mem_addr_i[4:2])};
    end else if (hit_status) begin
      rdata_next[`NESR_ST_PROC_BIT] = ~proc_err_reg;
      rdata_next[`NESR_ST_ADDR_BIT] = ~addr_err_reg;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_rdata_o <= 32'h0000_0000;
      mem_ack_o   <= 1'b0;
    end else begin
      mem_ack_o   <= mem_access;
      if (mem_rd_i) begin
        mem_rdata_o <= rdata_next;
      end
    end
  end

  // --------------------------------------------------------------------
  // Error routing
  // --------------------------------------------------------------------
  // The fault input follows the latched address error, so the processor
  // sees it as a lasting internal error until the node is reset.
  reg addr_err_d_reg;
  reg fault_next;
  reg event_next;
  reg analyse_next;
  reg addr_err_rise;

  // Each jumper column picks its own response, so any mix of them, none
  // at all included, may be fitted at once.
  always @* begin
    addr_err_rise = addr_err_reg & ~addr_err_d_reg;
    fault_next    = 1'b0;
    event_next    = 1'b0;
    analyse_next  = 1'b0;
    if (jmp_fault) begin
      fault_next = addr_err_reg;
    end
    if (jmp_event) begin
      event_next = addr_err_rise;
    end
    if (jmp_anal) begin
      analyse_next = lrst_any;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_err_d_reg         <= 1'b0;
      external_fault_input_o <= 1'b0;
      event_req_o            <= 1'b0;
      analyse_o              <= 1'b0;
      node_reset_o           <= 1'b0;
    end else begin
      addr_err_d_reg         <= addr_err_reg;
      external_fault_input_o <= fault_next;
      event_req_o            <= event_next;
      analyse_o              <= analyse_next;
      node_reset_o           <= lrst_any;
    end
  end

  // --------------------------------------------------------------------
  // Boot link selection
  // --------------------------------------------------------------------
  // All links have equal standing; only a true tie in one cycle falls back
  // to the lowest numbered link.
  function [1:0] first_link;
    input [3:0] act;
    begin
      if (act[0]) begin
        first_link = 2'h0;
      end else if (act[1]) begin
        first_link = 2'h1;
      end else if (act[2]) begin
        first_link = 2'h2;
      end else begin
        first_link = 2'h3;
      end
    end
  endfunction

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_boot_setting_o <= 1'b1;
      boot_link_o           <= 2'h0;
      boot_link_valid_o     <= 1'b0;
    end else if (lrst_any) begin
      serial_boot_setting_o <= 1'b1;
      boot_link_o           <= 2'h0;
      boot_link_valid_o     <= 1'b0;
    end else if (!boot_link_valid_o && (|rxact_s)) begin
      boot_link_o           <= first_link(rxact_s);
      boot_link_valid_o     <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Default configuration
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_rate_mbps_o    <= 8'h00;
      mem_access_cycles_o <= 4'h0;
    end else begin
      link_rate_mbps_o    <= `NESR_LINK_MBPS;
      mem_access_cycles_o <= MEM_CYC_W[3:0];
    end
  end

endmodule // nesr_top

// *** nesr_props.sv ***
// Concurrent checks on the ports of the node glue block.
// Assumes one system clock and the active-low master reset.
`timescale 1ns/100ps

module nesr_props (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic        mem_rd_i,
  input wire logic        mem_wr_i,
  input wire logic [2:0]  fault_routing_jumpers_i,
  input wire logic [31:0] mem_rdata_o,
  input wire logic        mem_ack_o,
  input wire logic [3:0]  link_reset_out_o,
  input wire logic        node_reset_o,
  input wire logic        analyse_o,
  input wire logic        event_req_o,
  input wire logic        external_fault_input_o,
  input wire logic [1:0]  boot_link_o,
  input wire logic        boot_link_valid_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  wire port_wr = mem_wr_i && mem_addr_i == 32'h0000_00c0;
  wire far_rd  = mem_rd_i && mem_addr_i > 32'h801f_ffff;

  a_ack_follow: assert property ((mem_rd_i || mem_wr_i) |=> mem_ack_o)
    else $error("no acknowledge after strobe");
  a_stat_fmt: assert property (mem_rd_i && mem_addr_i == 32'h80 |=>
    mem_rdata_o[31:2] == 30'h0) else $error("status upper bits set");
  a_id_upper: assert property (mem_rd_i && mem_addr_i < 32'h1c &&
    mem_addr_i[1:0] == 2'h0 |=> mem_rdata_o[31:8] == 24'h0)
    else $error("id word upper bits set");
  a_port_rd0: assert property (mem_rd_i && mem_addr_i == 32'hc0 |=>
    mem_rdata_o == 32'h0) else $error("reset port read not zero");
  a_fault_route: assert property (far_rd && fault_routing_jumpers_i[0] &&
    $past(fault_routing_jumpers_i[0], 4) |-> ##2 external_fault_input_o)
    else $error("fault output missing");
  a_event_one: assert property (event_req_o |=> !event_req_o)
    else $error("event request longer than one cycle");
  a_mask_cause: assert property (link_reset_out_o != $past(link_reset_out_o)
    |-> $past(port_wr)) else $error("link reset changed without port write");
  a_mask_hot: assert property (|link_reset_out_o |-> $onehot(link_reset_out_o))
    else $error("more than one link in reset");
  a_analyse_cause: assert property (analyse_o |-> node_reset_o)
    else $error("analyse without incoming reset");
  a_boot_hold: assert property (boot_link_valid_o ##1 boot_link_valid_o
    |-> $stable(boot_link_o)) else $error("boot link changed");
endmodule // nesr_props

bind nesr_top nesr_props nesr_props_inst (.sys_clk_i, .rst_b_i, .mem_addr_i,
  .mem_rd_i, .mem_wr_i, .fault_routing_jumpers_i, .mem_rdata_o, .mem_ack_o,
  .link_reset_out_o, .node_reset_o, .analyse_o, .event_req_o,
  .external_fault_input_o, .boot_link_o, .boot_link_valid_o);

// *** nesr_nbr_model.sv ***
// Four neighbouring nodes seen over the link reset and link lines.
// Assumes the bench changes the request vectors at the falling edge.
`timescale 1ns/100ps

module nesr_nbr_model (
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] rst_req_i,
  input  wire logic [3:0] msg_req_i,
  input  wire logic [3:0] link_reset_out_i,
  output logic [3:0]      link_reset_in_o,
  output logic [3:0]      link_rx_active_o,
  output logic [3:0]      in_boot_o
);
  // A neighbour once held in reset stays waiting for a new program.
  logic [3:0] boot_seen = 4'h0;

  assign link_reset_in_o  = rst_req_i;
  assign link_rx_active_o = msg_req_i;
  assign in_boot_o        = boot_seen;
  always @(posedge sys_clk_i) begin
    boot_seen <= boot_seen | link_reset_out_i;
  end
endmodule // nesr_nbr_model

// *** nesr_top_tb.sv ***
// Self-checking bench of the node glue block with its neighbour model.
// Assumes nesr_props is bound from its own file; one 20 MHz clock.
`timescale 1ns/100ps

module nesr_top_tb;
  logic        sys_clk = 0, rst_b = 0, rd = 0, wr = 0, perr = 0;
  logic [31:0] addr = 0, wdata = 0, rdata;
  logic [2:0]  jmp = 3'h7;
  logic [3:0]  rreq = 0, mreq = 0, lri, lra, lro, nboot, cyc;
  logic        ack, nrst, anl, evt, flt, sbs, bval;
  logic [1:0]  blink;
  logic [7:0]  rate;
  int          bad_count = 0, samples_checked = 0;

  always #25 sys_clk = ~sys_clk;

  nesr_top #(.BOARD_ID(56'h77_66_55_44_33_22_11)) nesr_top_inst (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .mem_addr_i(addr),
    .mem_wdata_i(wdata), .mem_rd_i(rd), .mem_wr_i(wr), .proc_error_i(perr),
    .link_reset_in_i(lri), .link_rx_active_i(lra),
    .fault_routing_jumpers_i(jmp), .mem_rdata_o(rdata), .mem_ack_o(ack),
    .link_reset_out_o(lro), .node_reset_o(nrst), .analyse_o(anl),
    .event_req_o(evt), .external_fault_input_o(flt),
    .serial_boot_setting_o(sbs), .boot_link_o(blink),
    .boot_link_valid_o(bval), .link_rate_mbps_o(rate),
    .mem_access_cycles_o(cyc));

  nesr_nbr_model nesr_nbr_model_inst (.sys_clk_i(sys_clk), .rst_req_i(rreq),
    .msg_req_i(mreq), .link_reset_out_i(lro), .link_reset_in_o(lri),
    .link_rx_active_o(lra), .in_boot_o(nboot));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // A strobe lasts one cycle; the answer is looked at in the next cycle.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    rd = !w;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    rd = 0;
    wr = 0;
    chk(ack, 1);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic wport(input logic [7:0] v);
    bus(1, 32'h0000_00c0, {24'h0, v});
  endtask

  task automatic unlock;
    wport(8'h00);
    wport(8'h01);
    wport(8'h02);
    wport(8'h03);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk(sbs, 1);
    chk(rate, 8'h0a);
    chk(cyc, 4'h2);
    chk(lro, 4'h0);
    $display("test reset values done");
  endtask

  task automatic t_id;
    for (int i = 0; i < 7; i++) rdchk(4 * i, (i + 1) * 32'h11);
    rdchk(32'h1c, 32'h0);
    rdchk(32'h40, 32'h0);
    rdchk(32'h80, 32'h3);
    rdchk(32'hc0, 32'h0);
    $display("test identification done");
  endtask

  task automatic t_unlock;
    wport(8'h08);
    chk(lro, 4'h0);
    wport(8'h00);
    wport(8'h01);
    wport(8'h03);
    wport(8'h04);
    chk(lro, 4'h0);
    unlock;
    wport(8'h05);
    wport(8'h02);
    chk(lro, 4'h0);
    for (int k = 0; k < 4; k++) begin
      unlock;
      wport(8'h01 << k);
      chk(lro, 4'h1 << k);
      wport(8'h03);
      chk(lro, 4'h1 << k);
      cyc_n(2560);
      chk(nboot[k], 1);
      wport(8'h00);
      chk(lro, 4'h0);
      wport(8'h01 << k);
      chk(lro, 4'h0);
    end
    $display("test link reset port done");
  endtask

  task automatic t_addr_err;
    rdchk(32'h801f_fffc, 32'h0);
    rdchk(32'h80, 32'h3);
    bus(0, 32'h8020_0000, 32'h0);
    cyc_n(1);
    chk(flt, 1);
    chk(evt, 1);
    cyc_n(1);
    chk(evt, 0);
    rdchk(32'h80, 32'h1);
    perr = 1;
    cyc_n(4);
    perr = 0;
    cyc_n(50);
    rdchk(32'h80, 32'h0);
    $display("test error latching done");
  endtask

  task automatic t_link_in;
    rreq = 4'h4;
    cyc_n(4);
    chk(nrst, 1);
    chk(anl, 1);
    rreq = 4'h0;
    cyc_n(4);
    chk(anl, 0);
    rdchk(32'h80, 32'h3);
    chk(flt, 0);
    jmp = 3'h0;
    cyc_n(5);
    rreq = 4'h1;
    cyc_n(4);
    chk(nrst, 1);
    chk(anl, 0);
    rreq = 4'h0;
    cyc_n(4);
    bus(0, 32'hffff_fff0, 32'h0);
    cyc_n(1);
    chk(flt, 0);
    chk(evt, 0);
    rdchk(32'h80, 32'h1);
    $display("test incoming link reset done");
  endtask

  task automatic t_boot;
    chk(bval, 0);
    mreq = 4'ha;
    cyc_n(5);
    chk(bval, 1);
    chk(blink, 2'h1);
    mreq = 4'h8;
    cyc_n(4);
    chk(blink, 2'h1);
    mreq = 4'h0;
    $display("test boot link done");
  endtask

  initial begin
    cyc_n(10);
    rst_b = 1;
    cyc_n(2);
    t_reset;
    t_id;
    t_unlock;
    t_addr_err;
    t_link_in;
    t_boot;
    tally_and_finish;
  end
endmodule // nesr_top_tb
